// [hw/dcc_consts.svh]
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// Register byte offsets
`define DCC_OFF_CTRL      8'h00
`define DCC_OFF_GUARD     8'h04
`define DCC_OFF_STATUS    8'h08

// Control register fields
`define DCC_CTRL_DTR_LSB  0
`define DCC_CTRL_RPT_BIT  2
`define DCC_CTRL_ESC_LSB  8

// Reset values
`define DCC_RST_ESC       8'h2B
`define DCC_RST_GUARD_MS  16'h03E8
`define DCC_RST_DTR_MODE  2'h0

// Timing
`define DCC_CLK_NS        25
`define DCC_MS_NS         1000000

// Characters
`define DCC_CH_CR         8'h0D
`define DCC_CH_A          8'h41
`define DCC_CH_T          8'h54
`define DCC_CH_D          8'h44
`define DCC_CH_H          8'h48
`define DCC_CH_O          8'h4F
`define DCC_CH_MENU       8'h3F
`define DCC_CH_COLON      8'h3A
`define DCC_CH_DASH       8'h2D
`define DCC_CH_SPACE      8'h20
`define DCC_CH_ZERO       8'h30
`define DCC_CH_NINE       8'h39

// Dial string layout
`define DCC_DIG_DEPTH     16
`define DCC_DEST_DIGITS   5'h06

`endif

// [hw/dcc_pkg.sv]
package dcc_pkg;

    typedef enum logic [1:0] {
        DCC_DTR_IGNORE,
        DCC_DTR_HANG_LOW,
        DCC_DTR_HANG_DROP,
        DCC_DTR_LOCAL_LOW
    } dcc_dtr_e;

    typedef enum logic [1:0] {
        DCC_RES_OK,
        DCC_RES_CONNECT,
        DCC_RES_NO_CARRIER,
        DCC_RES_ERROR
    } dcc_res_e;

    typedef enum {
        DCC_S_CMD,
        DCC_S_ROUTE,
        DCC_S_WAIT,
        DCC_S_ONLINE
    } dcc_state_e;

    typedef enum {
        DCC_P_IDLE,
        DCC_P_A,
        DCC_P_BODY
    } dcc_parse_e;

endpackage

// [hw/dcc_top.sv]
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "dcc_consts.svh"

// Behaviour
// - Hang-up command in local command state drops the link and answers OK.
// - Link closed by far end reports NO CARRIER to the terminal.
// - Ignore mode: terminal-ready has no effect on connection state.
// - Hang-up-on-low: low level drops link, even right after connecting.
// - Hang-up-on-drop: only a high-to-low edge drops the link.
// - Local-on-low: falling terminal-ready enters local command like escape.
// - Dial string routes through each listed repeater in order.
// - Dial-up repeater mode is selectable in configuration.
// - Repeater mode forces hang-up-on-drop terminal-ready behaviour.
// - Menu command opens the configuration menu.
// - Escape needs guard silence before and after; then local state, OK.
// - Online: all serial data forwarded; only the escape sequence is interpreted.
// - Dial carries four-digit destination and two-digit extension.
module dcc_top #(
    parameter int unsigned MS_CYCLES = `DCC_MS_NS / `DCC_CLK_NS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Terminal side
    input  wire logic        dtr,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             res_valid,
    output logic      [1:0]  res_code,
    // Radio side
    output logic             fwd_valid,
    output logic      [7:0]  fwd_data,
    output logic             route_valid,
    output logic      [15:0] route_addr,
    output logic      [7:0]  route_ext,
    output logic             route_last,
    output logic             hangup_req,
    output logic             menu_open,
    input  wire logic        radio_connected,
    input  wire logic        radio_dropped
);

    dcc_pkg::dcc_state_e state_q, state_d;
    dcc_pkg::dcc_parse_e ph_q, ph_d;
    dcc_pkg::dcc_dtr_e   mode_q, mode_d, mode_eff;
    dcc_pkg::dcc_res_e   last_q, last_d;
    logic [3:0]  dig_q [`DCC_DIG_DEPTH];
    logic [3:0]  dig_d [`DCC_DIG_DEPTH];
    logic [7:0]  cmd_q, cmd_d, esc_ch_q, esc_ch_d;
    logic [4:0]  ndig_q, ndig_d;
    logic [2:0]  idx_q, idx_d, hops_q, hops_d;
    logic [1:0]  esc_q, esc_d, res_code_d;
    logic [15:0] sil_q, sil_d, pre_q, pre_d, guard_q, guard_d;
    logic        bad_q, bad_d, link_q, link_d, rpt_q, rpt_d, dtr_prev_q;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d, res_valid_d, fwd_valid_d, route_valid_d;
    logic        route_last_d, hangup_d, menu_d;
    logic [7:0]  fwd_data_d, route_ext_d;
    logic [15:0] route_addr_d;
    logic        tick, fall, hang, to_local, apb_wr, is_digit, is_sep;
    logic [3:0]  rb, db;

    always_comb begin
        for (int i = 0; i < `DCC_DIG_DEPTH; i++) begin
            dig_d[i] = dig_q[i];
        end
        state_d       = state_q;
        ph_d          = ph_q;
        cmd_d         = cmd_q;
        ndig_d        = ndig_q;
        bad_d         = bad_q;
        idx_d         = idx_q;
        hops_d        = hops_q;
        link_d        = link_q;
        esc_d         = esc_q;
        last_d        = last_q;
        mode_d        = mode_q;
        rpt_d         = rpt_q;
        esc_ch_d      = esc_ch_q;
        guard_d       = guard_q;
        res_valid_d   = 1'b0;
        res_code_d    = res_code;
        fwd_valid_d   = 1'b0;
        fwd_data_d    = fwd_data;
        route_valid_d = 1'b0;
        route_addr_d  = route_addr;
        route_ext_d   = route_ext;
        route_last_d  = 1'b0;
        hangup_d      = 1'b0;
        menu_d        = 1'b0;

        // Millisecond timebase for the guard window
        tick  = (pre_q == 16'(MS_CYCLES - 1));
        pre_d = tick ? 16'h0000 : pre_q + 16'h0001;
        if (rx_valid) begin
            sil_d = 16'h0000;
        end else if (tick && sil_q != 16'hFFFF) begin
            sil_d = sil_q + 16'h0001;
        end else begin
            sil_d = sil_q;
        end

        // APB: zero wait states, answer prepared in the setup cycle
        pready_d  = psel & ~penable;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        apb_wr    = psel & penable & pwrite & pready;
        if (psel && !penable) begin
            case (paddr)
                `DCC_OFF_CTRL: begin
                    prdata_d = {16'h0000, esc_ch_q, 5'h00, rpt_q, mode_q};
                end
                `DCC_OFF_GUARD: begin
                    prdata_d = {16'h0000, guard_q};
                end
                `DCC_OFF_STATUS: begin
                    prdata_d = {20'h00000, 2'(state_q), 3'h0, 2'(last_q), 2'h0, link_q, 2'h0};
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        if (apb_wr && paddr == `DCC_OFF_CTRL) begin
            mode_d   = dcc_pkg::dcc_dtr_e'(pwdata[`DCC_CTRL_DTR_LSB +: 2]);
            rpt_d    = pwdata[`DCC_CTRL_RPT_BIT];
            esc_ch_d = pwdata[`DCC_CTRL_ESC_LSB +: 8];
        end
        if (apb_wr && paddr == `DCC_OFF_GUARD) begin
            guard_d = pwdata[15:0];
        end

        mode_eff = rpt_q ? dcc_pkg::DCC_DTR_HANG_DROP : mode_q;
        fall     = dtr_prev_q & ~dtr;
        hang     = link_q && ((mode_eff == dcc_pkg::DCC_DTR_HANG_LOW && !dtr) ||
                              (mode_eff == dcc_pkg::DCC_DTR_HANG_DROP && fall));
        to_local = state_q == dcc_pkg::DCC_S_ONLINE &&
                   ((mode_eff == dcc_pkg::DCC_DTR_LOCAL_LOW && fall) ||
                    (esc_q == 2'h3 && sil_q >= guard_q && !rx_valid));
        is_digit = rx_data >= `DCC_CH_ZERO && rx_data <= `DCC_CH_NINE;
        is_sep   = rx_data == `DCC_CH_COLON || rx_data == `DCC_CH_DASH ||
                   rx_data == `DCC_CH_SPACE;
        rb       = {idx_q, 1'b0};
        db       = 4'(ndig_q - `DCC_DEST_DIGITS);

        if (radio_dropped && link_q) begin
            link_d      = 1'b0;
            state_d     = dcc_pkg::DCC_S_CMD;
            res_valid_d = 1'b1;
            res_code_d  = dcc_pkg::DCC_RES_NO_CARRIER;
        end else if (hang) begin
            link_d      = 1'b0;
            hangup_d    = 1'b1;
            state_d     = dcc_pkg::DCC_S_CMD;
            res_valid_d = 1'b1;
            res_code_d  = dcc_pkg::DCC_RES_NO_CARRIER;
        end else if (to_local) begin
            state_d     = dcc_pkg::DCC_S_CMD;
            esc_d       = 2'h0;
            res_valid_d = 1'b1;
            res_code_d  = dcc_pkg::DCC_RES_OK;
        end else begin
            case (state_q)
                dcc_pkg::DCC_S_ONLINE: begin
                    if (rx_valid) begin
                        fwd_valid_d = 1'b1;
                        fwd_data_d  = rx_data;
                        if (rx_data == esc_ch_q && esc_q != 2'h3 &&
                            (esc_q != 2'h0 || sil_q >= guard_q)) begin
                            esc_d = esc_q + 2'h1;
                        end else begin
                            esc_d = 2'h0;
                        end
                    end
                end
                dcc_pkg::DCC_S_ROUTE, dcc_pkg::DCC_S_WAIT: begin
                    if (rx_valid) begin
                        // Any keystroke aborts the call attempt
                        hangup_d    = 1'b1;
                        state_d     = dcc_pkg::DCC_S_CMD;
                        res_valid_d = 1'b1;
                        res_code_d  = dcc_pkg::DCC_RES_NO_CARRIER;
                    end else if (state_q == dcc_pkg::DCC_S_ROUTE) begin
                        route_valid_d = 1'b1;
                        if (idx_q < hops_q) begin
                            route_addr_d = {8'h00, dig_q[rb], dig_q[rb + 4'h1]};
                            route_ext_d  = 8'h00;
                            idx_d        = idx_q + 3'h1;
                        end else begin
                            route_addr_d = {dig_q[db], dig_q[db + 4'h1],
                                            dig_q[db + 4'h2], dig_q[db + 4'h3]};
                            route_ext_d  = {dig_q[db + 4'h4], dig_q[db + 4'h5]};
                            route_last_d = 1'b1;
                            state_d      = dcc_pkg::DCC_S_WAIT;
                        end
                    end else if (radio_connected) begin
                        link_d      = 1'b1;
                        esc_d       = 2'h0;
                        state_d     = dcc_pkg::DCC_S_ONLINE;
                        res_valid_d = 1'b1;
                        res_code_d  = dcc_pkg::DCC_RES_CONNECT;
                    end else if (radio_dropped) begin
                        state_d     = dcc_pkg::DCC_S_CMD;
                        res_valid_d = 1'b1;
                        res_code_d  = dcc_pkg::DCC_RES_NO_CARRIER;
                    end
                end
                dcc_pkg::DCC_S_CMD: begin
                    if (rx_valid) begin
                        case (ph_q)
                            dcc_pkg::DCC_P_IDLE: begin
                                if (rx_data == `DCC_CH_A) begin
                                    ph_d = dcc_pkg::DCC_P_A;
                                end
                            end
                            dcc_pkg::DCC_P_A: begin
                                ph_d   = (rx_data == `DCC_CH_T) ? dcc_pkg::DCC_P_BODY
                                                                : dcc_pkg::DCC_P_IDLE;
                                cmd_d  = 8'h00;
                                ndig_d = 5'h00;
                                bad_d  = 1'b0;
                            end
                            dcc_pkg::DCC_P_BODY: begin
                                if (rx_data != `DCC_CH_CR) begin
                                    if (cmd_q == 8'h00) begin
                                        cmd_d = rx_data;
                                    end else if (cmd_q == `DCC_CH_D && is_digit &&
                                                 ndig_q != 5'(`DCC_DIG_DEPTH)) begin
                                        dig_d[ndig_q[3:0]] = rx_data[3:0];
                                        ndig_d             = ndig_q + 5'h01;
                                    end else if (!(cmd_q == `DCC_CH_D && is_sep)) begin
                                        bad_d = 1'b1;
                                    end
                                end else begin
                                    ph_d        = dcc_pkg::DCC_P_IDLE;
                                    res_valid_d = 1'b1;
                                    res_code_d  = dcc_pkg::DCC_RES_OK;
                                    if (bad_q) begin
                                        res_code_d = dcc_pkg::DCC_RES_ERROR;
                                    end else if (cmd_q == `DCC_CH_H) begin
                                        hangup_d = link_q;
                                        link_d   = 1'b0;
                                    end else if (cmd_q == `DCC_CH_O) begin
                                        if (link_q) begin
                                            state_d    = dcc_pkg::DCC_S_ONLINE;
                                            esc_d      = 2'h0;
                                            res_code_d = dcc_pkg::DCC_RES_CONNECT;
                                        end else begin
                                            res_code_d = dcc_pkg::DCC_RES_ERROR;
                                        end
                                    end else if (cmd_q == `DCC_CH_MENU) begin
                                        menu_d = 1'b1;
                                    end else if (cmd_q == `DCC_CH_D) begin
                                        // even count of at least six digits
                                        if (link_q || ndig_q < `DCC_DEST_DIGITS ||
                                            ndig_q[0]) begin
                                            res_code_d = dcc_pkg::DCC_RES_ERROR;
                                        end else begin
                                            res_valid_d = 1'b0;
                                            res_code_d  = res_code;
                                            idx_d       = 3'h0;
                                            hops_d      = 3'((ndig_q - `DCC_DEST_DIGITS) >> 1);
                                            state_d     = dcc_pkg::DCC_S_ROUTE;
                                        end
                                    end else if (cmd_q != 8'h00) begin
                                        res_code_d = dcc_pkg::DCC_RES_ERROR;
                                    end
                                end
                            end
                            default: begin
                                ph_d = dcc_pkg::DCC_P_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    state_d = dcc_pkg::DCC_S_CMD;
                end
            endcase
        end
        if (res_valid_d) begin
            last_d = dcc_pkg::dcc_res_e'(res_code_d);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < `DCC_DIG_DEPTH; i++) begin
                dig_q[i] <= 4'h0;
            end
            state_q     <= dcc_pkg::DCC_S_CMD;
            ph_q        <= dcc_pkg::DCC_P_IDLE;
            mode_q      <= dcc_pkg::dcc_dtr_e'(`DCC_RST_DTR_MODE);
            last_q      <= dcc_pkg::DCC_RES_OK;
            cmd_q       <= 8'h00;
            esc_ch_q    <= `DCC_RST_ESC;
            ndig_q      <= 5'h00;
            idx_q       <= 3'h0;
            hops_q      <= 3'h0;
            esc_q       <= 2'h0;
            sil_q       <= 16'h0000;
            pre_q       <= 16'h0000;
            guard_q     <= `DCC_RST_GUARD_MS;
            bad_q       <= 1'b0;
            link_q      <= 1'b0;
            rpt_q       <= 1'b0;
            dtr_prev_q  <= 1'b0;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            res_valid   <= 1'b0;
            res_code    <= 2'h0;
            fwd_valid   <= 1'b0;
            fwd_data    <= 8'h00;
            route_valid <= 1'b0;
            route_addr  <= 16'h0000;
            route_ext   <= 8'h00;
            route_last  <= 1'b0;
            hangup_req  <= 1'b0;
            menu_open   <= 1'b0;
        end else begin
            dig_q       <= dig_d;
            state_q     <= state_d;
            ph_q        <= ph_d;
            mode_q      <= mode_d;
            last_q      <= last_d;
            cmd_q       <= cmd_d;
            esc_ch_q    <= esc_ch_d;
            ndig_q      <= ndig_d;
            idx_q       <= idx_d;
            hops_q      <= hops_d;
            esc_q       <= esc_d;
            sil_q       <= sil_d;
            pre_q       <= pre_d;
            guard_q     <= guard_d;
            bad_q       <= bad_d;
            link_q      <= link_d;
            rpt_q       <= rpt_d;
            dtr_prev_q  <= dtr;
            prdata      <= prdata_d;
            pready      <= pready_d;
            pslverr     <= pslverr_d;
            res_valid   <= res_valid_d;
            res_code    <= res_code_d;
            fwd_valid   <= fwd_valid_d;
            fwd_data    <= fwd_data_d;
            route_valid <= route_valid_d;
            route_addr  <= route_addr_d;
            route_ext   <= route_ext_d;
            route_last  <= route_last_d;
            hangup_req  <= hangup_d;
            menu_open   <= menu_d;
        end
    end

endmodule // dcc_top

// [verif/dcc_checker_assertions.sv]
`timescale 1ns/100ps
module dcc_checker #(
    parameter int unsigned MS_CYCLES = 40000
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Register bus
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Terminal and radio
    input wire logic        dtr,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        res_valid,
    input wire logic [1:0]  res_code,
    input wire logic        fwd_valid,
    input wire logic [7:0]  fwd_data,
    input wire logic        route_valid,
    input wire logic [15:0] route_addr,
    input wire logic [7:0]  route_ext,
    input wire logic        route_last,
    input wire logic        hangup_req
);
    // Shadow of the mode bits, so terminal-ready checks know the mode
    logic [2:0] cfg_q, cfg_d;

    always_comb cfg_d = (psel && penable && pready && pwrite && paddr == 8'h00) ?
                        pwdata[2:0] : cfg_q;
    always_ff @(posedge clk_sys) cfg_q <= rst_n ? cfg_d : 3'h0;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer is not a single cycle");
    a_apb_unmapped: assert property (psel && !penable && paddr > 8'h08
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_res_single: assert property (res_valid && $past(res_valid) |-> res_code != $past(res_code))
        else $error("result strobe longer than one cycle");
    a_code_hold: assert property (!res_valid |-> $stable(res_code))
        else $error("result code moved without a strobe");
    a_fwd_echo: assert property (
        fwd_valid |-> $past(rx_valid) && fwd_data == $past(rx_data))
        else $error("forwarded byte differs from received byte");
    a_route_rpt: assert property (
        route_valid && !route_last |-> route_addr[15:8] == 8'h00 && route_ext == 8'h00)
        else $error("repeater entry malformed");
    a_ignore_dtr: assert property (
        cfg_q == 3'h0 && $fell(dtr) |=> (!hangup_req && !res_valid) [*4])
        else $error("terminal-ready acted on in ignore mode");
    a_dtr_hang: assert property (
        (cfg_q[2] || cfg_q[1:0] == 2'h1 || cfg_q[1:0] == 2'h2) && $fell(dtr) |-> ##[1:6] hangup_req)
        else $error("terminal-ready drop did not hang up");
    a_local_ok: assert property (
        cfg_q == 3'h3 && $fell(dtr) |-> ##[1:6] res_valid && res_code == dcc_pkg::DCC_RES_OK)
        else $error("terminal-ready drop did not enter local state");
endmodule // dcc_checker

bind dcc_top dcc_checker #(.MS_CYCLES(MS_CYCLES)) i_dcc_checker (
    .clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .dtr, .rx_valid, .rx_data, .res_valid, .res_code, .fwd_valid, .fwd_data,
    .route_valid, .route_addr, .route_ext, .route_last, .hangup_req
);

// [verif/dcc_term.sv]
`timescale 1ns/100ps
module dcc_term (
    // Clock
    input wire logic   clk_sys,
    // Terminal lines
    output logic       dtr,
    output logic       rx_valid,
    output logic [7:0] rx_data
);
    initial begin
        dtr = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end

    // Idle data carries the inverse, so a stale byte is never reused
    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= s[i];
            @(posedge clk_sys);
            rx_valid <= 1'b0;
            rx_data <= ~s[i];
            @(posedge clk_sys);
        end
    endtask

    task automatic set_dtr(input logic v);
        dtr <= v;
        @(posedge clk_sys);
    endtask
endmodule // dcc_term

// [verif/tb_dcc_top.sv]
`timescale 1ns/100ps
module tb_dcc_top;
    localparam logic [1:0] RES_OK  = dcc_pkg::DCC_RES_OK;
    localparam logic [1:0] RES_CON = dcc_pkg::DCC_RES_CONNECT;
    localparam logic [1:0] RES_NC  = dcc_pkg::DCC_RES_NO_CARRIER;
    localparam logic [1:0] RES_ERR = dcc_pkg::DCC_RES_ERROR;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        radio_connected, radio_dropped;
    logic [31:0] prdata, rd;
    logic [15:0] route_addr;
    logic [7:0]  rx_data, fwd_data, route_ext;
    logic        pready, pslverr, dtr, rx_valid, res_valid, fwd_valid, err;
    logic        route_valid, route_last, hangup_req, menu_open;
    logic [1:0]  res_code, res_q[$];
    logic [24:0] routes[$];
    int          n_mismatch = 0, samples_checked = 0;
    int          n_hang = 0, n_fwd = 0, n_menu = 0, cyc = 0;

    always #12.5 clk_sys = ~clk_sys;

    dcc_top #(.MS_CYCLES(4)) i_dcc_top (
        .clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .dtr, .rx_valid, .rx_data, .res_valid, .res_code, .fwd_valid, .fwd_data,
        .route_valid, .route_addr, .route_ext, .route_last, .hangup_req, .menu_open,
        .radio_connected, .radio_dropped
    );
    dcc_term i_dcc_term (.clk_sys, .dtr, .rx_valid, .rx_data);

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        n_hang <= n_hang + int'(hangup_req === 1'b1);
        n_fwd <= n_fwd + int'(fwd_valid === 1'b1);
        n_menu <= n_menu + int'(menu_open === 1'b1);
        if (res_valid === 1'b1) res_q.push_back(res_code);
        if (route_valid === 1'b1) routes.push_back({route_last, route_addr, route_ext});
        if (cyc == 40000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wait_res(input logic [1:0] code);
        for (int k = 0; k < 3000 && res_q.size() == 0; k++) @(posedge clk_sys);
        if (res_q.size() == 0) res_q.push_back(~code);
        chk(32'(res_q.pop_front()), 32'(code));
    endtask

    task automatic dial_up(input string s, input logic wait_con);
        i_dcc_term.send_str(s);
        tick(20);
        radio_connected <= 1'b1;
        @(posedge clk_sys);
        radio_connected <= 1'b0;
        if (wait_con) wait_res(RES_CON);
    endtask

    task automatic escape(input string s);
        // Guard of 200 ms is 800 cycles here
        tick(1000);
        i_dcc_term.send_str(s);
        wait_res(RES_OK);
    endtask

    task automatic hang_up();
        int h;
        h = n_hang;
        escape("+++");
        i_dcc_term.send_str("ATH\015");
        wait_res(RES_OK);
        tick(2);
        chk(32'(n_hang - h), 32'h1);
    endtask

    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00002B00);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h000003E8);
        apb(1'b1, 8'h04, 32'h000000C8);
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        apb(1'b0, 8'h0C, 32'h0);
        chk({rd[31:1], err}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h000000C8);
        $display("regs done");
    endtask

    task automatic t_cmds();
        i_dcc_term.send_str("AT?\015");
        tick(4);
        chk(32'(n_menu), 32'h1);
        res_q.delete();
        i_dcc_term.send_str("ATX\015");
        wait_res(RES_ERR);
        $display("cmds done");
    endtask

    task automatic t_dial();
        int f;
        routes.delete();
        dial_up("ATD10-43:2200 01\015", 1'b1);
        chk(32'(routes.size()), 32'h3);
        chk(32'(routes[0]), 32'h00001000);
        chk(32'(routes[1]), 32'h00004300);
        chk(32'(routes[2]), 32'h01220001);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h00000C24);
        f = n_fwd;
        i_dcc_term.send_str("ATH\015");
        tick(2);
        chk(32'(n_fwd - f), 32'h4);
        chk(32'(res_q.size()), 32'h0);
        hang_up();
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        $display("dial done");
    endtask

    task automatic t_dtr();
        int h;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h00, 32'h00002B00 + 32'(m));
            dial_up("ATD220000\015", 1'b1);
            h = n_hang;
            i_dcc_term.set_dtr(1'b0);
            case (m)
                0: begin
                    tick(10);
                    chk(32'(res_q.size()), 32'h0);
                    hang_up();
                end
                3: begin
                    wait_res(RES_OK);
                    i_dcc_term.send_str("ATH\015");
                    wait_res(RES_OK);
                end
                default: begin
                    wait_res(RES_NC);
                    tick(2);
                    chk(32'(n_hang - h), 32'h1);
                end
            endcase
            i_dcc_term.set_dtr(1'b1);
        end
        $display("dtr modes done");
    endtask

    task automatic t_low_dial();
        int h;
        apb(1'b1, 8'h00, 32'h00002B00);
        i_dcc_term.set_dtr(1'b0);
        apb(1'b1, 8'h00, 32'h00002B02);
        h = n_hang;
        dial_up("ATD220000\015", 1'b1);
        tick(20);
        chk(32'(n_hang - h), 32'h0);
        radio_dropped <= 1'b1;
        @(posedge clk_sys);
        radio_dropped <= 1'b0;
        wait_res(RES_NC);
        apb(1'b1, 8'h00, 32'h00002B01);
        h = n_hang;
        dial_up("ATD220000\015", 1'b0);
        tick(20);
        chk(32'(n_hang > h), 32'h1);
        res_q.delete();
        i_dcc_term.set_dtr(1'b1);
        $display("low dial done");
    endtask

    task automatic t_rpt();
        apb(1'b1, 8'h00, 32'h00002D04);
        dial_up("ATD220000\015", 1'b1);
        escape("---");
        i_dcc_term.send_str("ATO\015");
        wait_res(RES_CON);
        i_dcc_term.set_dtr(1'b0);
        wait_res(RES_NC);
        i_dcc_term.set_dtr(1'b1);
        $display("repeater done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        radio_connected <= 1'b0;
        radio_dropped <= 1'b0;
        tick(20);
        rst_n <= 1'b1;
        tick(1);
        t_regs();
        t_cmds();
        t_dial();
        t_dtr();
        t_low_dial();
        t_rpt();
        report_and_stop();
    end
endmodule // tb_dcc_top
